/* File: hw/fewc_ctrl.sv */
`timescale 1ns/1ns
`include "fewc_defs.svh"
// Function
// - flash start launches op, self-clears
// - software clear of start ignored while running
// - page program collects up to 16 latches
// - selection bits self-clear at completion
// - chip erase runs on start alone
// - byte program takes one latched pair
// - suspend halts sector erase, clears busy in time
// - resume: clear suspend, set start again
// - while suspended refuse eeprom updates
// - protection program takes up to four bytes
// - flash busy sets on first latch/chip start
// - busy flash reads ff, writes ignored while running/waking
// - flash busy held after power-up/power-down exit
// - eeprom start launches op, self-clears
// - eeprom page update collects 16 latches
// - eeprom chip erase on start
// - eeprom busy, reads ff, writes ignored while running/waking
// - eeprom busy held after power-up/down exit
// - wait picks standby or power-down after writes
// - halt/stop power-down deferred until writes end
// - irq select routes pin or end-of-write
// - clearing selection cancels, drops latches
module fewc_ctrl #(
  parameter int unsigned FWAKE_CYC = `FEWC_FWAKE_CYC,
  parameter int unsigned EWAKE_CYC = `FEWC_EWAKE_CYC,
  parameter int unsigned SUSP_CYC  = `FEWC_SUSP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [23:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        flash_wr,
  input  wire logic        eeprom_wr,
  input  wire logic        array_rd,
  input  wire logic        flash_sel,
  input  wire logic [7:0]  array_rdata,
  output logic      [7:0]  array_data_out,
  output logic             latch_strobe,
  output logic      [4:0]  latch_count,
  input  wire logic        flash_op_done,
  input  wire logic        eeprom_op_done,
  output logic             flash_op_go,
  output logic             eeprom_op_go,
  output logic             flash_suspend_req,
  input  wire logic        wait_instruction,
  input  wire logic        halt_stop,
  input  wire logic        wake,
  output logic             flash_standby,
  output logic             mem_power_down,
  input  wire logic        ext_irq,
  output logic             shared_interrupt_channel
);
  // *********************
  // register state
  // *********************
  logic [7:0] flash_op_control, next_fcr, eeprom_op_control, next_ecr;
  logic [4:0] fcnt, next_fcnt, ecnt, next_ecnt;
  fewc_pkg::fewc_fstate_e fst, next_fst;
  fewc_pkg::fewc_pwr_e pwr, next_pwr;
  logic erun, next_erun;
  logic [23:0] wake_cnt, next_wake_cnt;
  logic [23:0] susp_cnt, next_susp_cnt;
  logic next_fgo, next_ego, next_eow;
  logic [23:0] susp_age, next_susp_age;
  logic halt_pend, next_halt_pend, wait_pend, next_wait_pend;
  logic [7:0] next_rdata, next_adata;
  logic next_strobe;
  logic [4:0] next_lcnt;

  function automatic logic hit(input logic [23:0] a, input logic [23:0] p, input logic [23:0] q);
    return (a == p) || (a == q);
  endfunction

  function automatic logic flash_busy_flag_run(input fewc_pkg::fewc_fstate_e s);
    return (s == fewc_pkg::FEWC_RUN) || (s == fewc_pkg::FEWC_SUSP_WAIT);
  endfunction

  logic fcr_w, ecr_w, flash_busy_flag, eeprom_busy_flag, fprog_sel, fwakeup, ewakeup, suspended;
  assign fcr_w     = reg_wr && hit(reg_addr, `FEWC_FCR_ADDR, `FEWC_FCR_ALT_ADDR);
  assign ecr_w     = reg_wr && hit(reg_addr, `FEWC_ECR_ADDR, `FEWC_ECR_ALT_ADDR);
  assign suspended = (fst == fewc_pkg::FEWC_SUSPENDED);
  assign fprog_sel = flash_op_control[`FEWC_F_PAGE] | flash_op_control[`FEWC_F_BYTE] | flash_op_control[`FEWC_F_SECT] | flash_op_control[`FEWC_F_PROTECTION_PROGRAM_SELECT];
  assign fwakeup   = (wake_cnt != 24'h000000) && (wake_cnt > 24'(EWAKE_CYC - FWAKE_CYC));
  assign ewakeup   = (wake_cnt != 24'h000000);
  assign flash_busy_flag     = flash_op_control[`FEWC_F_BUSY] | fwakeup;
  assign eeprom_busy_flag     = eeprom_op_control[`FEWC_E_BUSY] | ewakeup;

  // *********************
  // flash and eeprom sequencing
  // *********************
  always_comb begin
    logic [4:0] fmax;
    fmax      = flash_op_control[`FEWC_F_BYTE] ? 5'h01 : (flash_op_control[`FEWC_F_SECT] ? 5'h06 : (flash_op_control[`FEWC_F_PROTECTION_PROGRAM_SELECT] ? 5'h04 : 5'h10));
    next_fcr  = flash_op_control;
    next_ecr  = eeprom_op_control;
    next_fcnt = fcnt;
    next_ecnt = ecnt;
    next_fst  = fst;
    next_erun = erun;
    next_fgo  = 1'b0;
    next_ego  = 1'b0;
    next_eow  = 1'b0;
    next_susp_cnt = susp_cnt;
    next_strobe = 1'b0;
    next_lcnt = latch_count;
    if (fcr_w) begin
      next_fcr[7:1] = {flash_op_control[7] | reg_wdata[7], reg_wdata[6:1]};
      if (fst == fewc_pkg::FEWC_RUN || fst == fewc_pkg::FEWC_SUSP_WAIT) begin
        next_fcr[6:3] = flash_op_control[6:3];
        next_fcr[1]   = flash_op_control[1];
      end
      if (fst == fewc_pkg::FEWC_IDLE && (reg_wdata[6:3] == 4'h0) && !reg_wdata[1]) begin
        next_fcnt = 5'h00;
        next_fcr[`FEWC_F_BUSY] = 1'b0;
      end
    end
    if (ecr_w) begin
      next_ecr[7:1] = {eeprom_op_control[7] | reg_wdata[7], erun ? eeprom_op_control[6:5] : reg_wdata[6:5], 2'b00, reg_wdata[2:1]};
      if (!erun && !reg_wdata[6]) begin
        next_ecnt = 5'h00;
        next_ecr[`FEWC_E_BUSY] = 1'b0;
      end
    end
    if (flash_wr && !flash_busy_flag_run(fst) && fprog_sel && (fcnt < fmax) && !fwakeup) begin
      next_fcnt   = fcnt + 5'h01;
      next_strobe = 1'b1;
      next_lcnt   = fcnt + 5'h01;
      if (!suspended) next_fcr[`FEWC_F_BUSY] = 1'b1;
    end
    if (eeprom_wr && !erun && eeprom_op_control[`FEWC_E_PAGE] && (ecnt < 5'h10) && !suspended && !ewakeup) begin
      next_ecnt   = ecnt + 5'h01;
      next_strobe = 1'b1;
      next_lcnt   = ecnt + 5'h01;
      next_ecr[`FEWC_E_BUSY] = 1'b1;
    end
    unique case (fst)
      fewc_pkg::FEWC_IDLE: begin
        if (next_fcr[`FEWC_F_START] && ((fprog_sel && fcnt != 5'h00) || flash_op_control[`FEWC_F_CHIP])) begin
          next_fst = fewc_pkg::FEWC_RUN;
          next_fgo = 1'b1;
          next_fcr[`FEWC_F_BUSY] = 1'b1;
        end
      end
      fewc_pkg::FEWC_RUN: begin
        if (flash_op_control[`FEWC_F_SUSP] && flash_op_control[`FEWC_F_SECT]) begin
          next_fst = fewc_pkg::FEWC_SUSP_WAIT;
          next_susp_cnt = 24'h000000;
        end else if (flash_op_done) begin
          next_fcr = flash_op_control & 8'h04;
          next_fcnt = 5'h00;
          next_fst = fewc_pkg::FEWC_IDLE;
          next_eow = 1'b1;
        end
      end
      fewc_pkg::FEWC_SUSP_WAIT: begin
        next_susp_cnt = susp_cnt + 24'h000001;
        if (susp_cnt >= 24'(SUSP_CYC - 2)) begin
          next_fst = fewc_pkg::FEWC_SUSPENDED;
          next_fcr[`FEWC_F_START] = 1'b0;
          next_fcr[`FEWC_F_BUSY]  = 1'b0;
        end
      end
      fewc_pkg::FEWC_SUSPENDED: begin
        if (!flash_op_control[`FEWC_F_SUSP] && flash_op_control[`FEWC_F_START]) begin
          next_fst = fewc_pkg::FEWC_RUN;
          next_fcr[`FEWC_F_BUSY] = 1'b1;
          next_fgo = 1'b1;
        end
      end
    endcase
    if (!erun) begin
      if (next_ecr[`FEWC_E_START] && ((eeprom_op_control[`FEWC_E_PAGE] && ecnt != 5'h00) || eeprom_op_control[`FEWC_E_CHIP]) && !suspended) begin
        next_erun = 1'b1;
        next_ego  = 1'b1;
        next_ecr[`FEWC_E_BUSY] = 1'b1;
      end
    end else if (eeprom_op_done) begin
      next_erun = 1'b0;
      next_ecr  = {3'b000, 2'b00, eeprom_op_control[2:1], 1'b0};
      next_ecnt = 5'h00;
      next_eow  = 1'b1;
    end
    // *********************
    // reads
    // *********************
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (hit(reg_addr, `FEWC_FCR_ADDR, `FEWC_FCR_ALT_ADDR)) next_rdata = {flash_op_control[7:1], flash_busy_flag};
      else if (hit(reg_addr, `FEWC_ECR_ADDR, `FEWC_ECR_ALT_ADDR)) next_rdata = {eeprom_op_control[7:1], eeprom_busy_flag};
      else next_rdata = 8'h00;
    end
    next_adata = array_data_out;
    if (array_rd) next_adata = (flash_sel ? flash_busy_flag : eeprom_busy_flag) ? `FEWC_ERASED : array_rdata;
  end

  // *********************
  // power and wake
  // *********************
  logic writing;
  assign writing = flash_busy_flag_run(fst) | erun;
  always_comb begin
    next_pwr = pwr;
    next_wake_cnt = (wake_cnt != 24'h000000) ? wake_cnt - 24'h000001 : wake_cnt;
    // requests are pulses: keep them until the write ends
    next_halt_pend = (pwr == fewc_pkg::FEWC_PWR_ON) & (halt_pend | halt_stop);
    next_wait_pend = (pwr == fewc_pkg::FEWC_PWR_ON) & (wait_pend | wait_instruction);
    unique case (pwr)
      fewc_pkg::FEWC_PWR_ON: begin
        if (!writing && next_halt_pend) next_pwr = fewc_pkg::FEWC_PWR_DOWN;
        else if (!writing && next_wait_pend)
          next_pwr = eeprom_op_control[`FEWC_E_WAIT_SLEEP_DEPTH_SELECT] ? fewc_pkg::FEWC_PWR_DOWN : fewc_pkg::FEWC_STANDBY;
        if (!writing) begin
          next_halt_pend = 1'b0;
          next_wait_pend = 1'b0;
        end
      end
      fewc_pkg::FEWC_STANDBY: if (wake) next_pwr = fewc_pkg::FEWC_PWR_ON;
      fewc_pkg::FEWC_PWR_DOWN: begin
        if (wake) begin
          next_pwr = fewc_pkg::FEWC_PWR_ON;
          next_wake_cnt = 24'(EWAKE_CYC);
        end
      end
      default: next_pwr = fewc_pkg::FEWC_PWR_ON;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_op_control <= `FEWC_FCR_RESET;
      eeprom_op_control <= `FEWC_ECR_RESET;
      fcnt <= 5'h00;
      ecnt <= 5'h00;
      fst <= fewc_pkg::FEWC_IDLE;
      erun <= 1'b0;
      susp_cnt <= 24'h000000;
      susp_age <= 24'h000000;
      pwr <= fewc_pkg::FEWC_PWR_ON;
      wake_cnt <= 24'(EWAKE_CYC);
      reg_rdata <= 8'h00;
      array_data_out <= 8'h00;
      latch_strobe <= 1'b0;
      latch_count <= 5'h00;
      flash_op_go <= 1'b0;
      eeprom_op_go <= 1'b0;
      flash_suspend_req <= 1'b0;
      flash_standby <= 1'b0;
      mem_power_down <= 1'b0;
      halt_pend <= 1'b0;
      wait_pend <= 1'b0;
      shared_interrupt_channel <= 1'b0;
    end else begin
      flash_op_control <= next_fcr;
      eeprom_op_control <= next_ecr;
      fcnt <= next_fcnt;
      ecnt <= next_ecnt;
      fst <= next_fst;
      erun <= next_erun;
      susp_cnt <= next_susp_cnt;
      susp_age <= next_susp_age;
      pwr <= next_pwr;
      wake_cnt <= next_wake_cnt;
      reg_rdata <= next_rdata;
      array_data_out <= next_adata;
      latch_strobe <= next_strobe;
      latch_count <= next_lcnt;
      flash_op_go <= next_fgo;
      eeprom_op_go <= next_ego;
      flash_suspend_req <= (next_fst == fewc_pkg::FEWC_SUSP_WAIT);
      flash_standby <= (next_pwr == fewc_pkg::FEWC_STANDBY);
      mem_power_down <= (next_pwr == fewc_pkg::FEWC_PWR_DOWN);
      halt_pend <= next_halt_pend;
      wait_pend <= next_wait_pend;
      shared_interrupt_channel <= eeprom_op_control[`FEWC_E_IRQSEL] ? next_eow : ext_irq;
    end
  end

  // *********************
  // checks
  // *********************
  // age of a pending suspend
  always_comb begin
    next_susp_age = 24'h000000;
    if (flash_busy_flag_run(fst) && flash_op_control[`FEWC_F_SUSP] && flash_op_control[`FEWC_F_SECT] && flash_op_control[`FEWC_F_BUSY])
      next_susp_age = susp_age + 24'h000001;
  end
  susp_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (flash_busy_flag_run(fst) && flash_op_control[`FEWC_F_SUSP] && flash_op_control[`FEWC_F_SECT] && flash_op_control[`FEWC_F_BUSY]) |-> susp_age < 24'(SUSP_CYC))
    else $error("suspend too slow");
  start_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fst == fewc_pkg::FEWC_RUN && !flash_op_done && !flash_op_control[`FEWC_F_SUSP]) |=> flash_op_control[`FEWC_F_START]) else $error("start lost");
  done_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fst == fewc_pkg::FEWC_RUN && flash_op_done && !flash_op_control[`FEWC_F_SUSP]) |=> (flash_op_control[7:3] == 5'h00 && !flash_op_control[1])) else $error("sel kept");
  busy_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (array_rd && flash_sel && flash_busy_flag) |=> array_data_out == 8'hff) else $error("busy read not ff");
  eep_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (suspended && eeprom_wr) |=> $stable(ecnt)) else $error("eeprom update in suspend");
  pwr_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
    writing |=> !$rose(mem_power_down)) else $error("power-down during write");
endmodule // fewc_ctrl

/* File: pkg/fewc_defs.svh */
`ifndef FEWC_DEFS_SVH
`define FEWC_DEFS_SVH
// register offsets (two mirrors)
`define FEWC_FCR_ADDR      24'h224000
`define FEWC_ECR_ADDR      24'h224001
`define FEWC_FCR_ALT_ADDR  24'h221000
`define FEWC_ECR_ALT_ADDR  24'h221001
// flash control fields
`define FEWC_F_START   7
`define FEWC_F_PAGE    6
`define FEWC_F_CHIP    5
`define FEWC_F_BYTE    4
`define FEWC_F_SECT    3
`define FEWC_F_SUSP    2
`define FEWC_F_PROTECTION_PROGRAM_SELECT    1
`define FEWC_F_BUSY    0
// eeprom control fields
`define FEWC_E_START   7
`define FEWC_E_PAGE    6
`define FEWC_E_CHIP    5
`define FEWC_E_WAIT_SLEEP_DEPTH_SELECT    2
`define FEWC_E_IRQSEL  1
`define FEWC_E_BUSY    0
`define FEWC_FCR_RESET 8'h00
`define FEWC_ECR_RESET 8'h00
`define FEWC_ERASED    8'hff
// timing
`define FEWC_CLK_MHZ        250
`define FEWC_SUSP_MAX_NS    15000
`define FEWC_SUSP_CYC       ((`FEWC_SUSP_MAX_NS * `FEWC_CLK_MHZ) / 1000)
`define FEWC_FWAKE_MAX_NS   10000
`define FEWC_FWAKE_CYC      ((`FEWC_FWAKE_MAX_NS * `FEWC_CLK_MHZ) / 1000)
`define FEWC_EWAKE_MAX_MS   10
`define FEWC_EWAKE_CYC      (`FEWC_EWAKE_MAX_MS * 1000 * `FEWC_CLK_MHZ)
`endif

/* File: pkg/fewc_pkg.sv */
package fewc_pkg;
  typedef enum logic [1:0] {FEWC_IDLE, FEWC_RUN, FEWC_SUSP_WAIT, FEWC_SUSPENDED} fewc_fstate_e;
  typedef enum logic [1:0] {FEWC_PWR_ON, FEWC_STANDBY, FEWC_PWR_DOWN} fewc_pwr_e;
endpackage

/* File: tb/fewc_ctrl_tb_top.sv */
`timescale 1ns/1ns
`include "fewc_defs.svh"
module fewc_ctrl_tb_top;
  // ************************************************
  // stimulus and design
  // ************************************************
  localparam int unsigned FW = 20;
  localparam int unsigned EW = 40;
  localparam int unsigned SC = 8;
  logic        clk, rst_n, reg_wr, reg_rd, flash_wr, eeprom_wr, array_rd, flash_sel;
  logic        flash_op_done, eeprom_op_done, wait_instruction, halt_stop, wake, ext_irq;
  logic [23:0] reg_addr;
  logic [7:0]  reg_wdata, array_rdata, reg_rdata, array_data_out;
  logic        latch_strobe, flash_op_go, eeprom_op_go, flash_suspend_req;
  logic        flash_standby, mem_power_down, shared_interrupt_channel;
  logic [4:0]  latch_count;
  int          n_errors, check_count, cyc;
  fewc_ctrl #(.FWAKE_CYC(FW), .EWAKE_CYC(EW), .SUSP_CYC(SC)) dut_u (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flash_wr(flash_wr), .eeprom_wr(eeprom_wr),
    .array_rd(array_rd), .flash_sel(flash_sel), .array_rdata(array_rdata),
    .array_data_out(array_data_out), .latch_strobe(latch_strobe), .latch_count(latch_count),
    .flash_op_done(flash_op_done), .eeprom_op_done(eeprom_op_done), .flash_op_go(flash_op_go),
    .eeprom_op_go(eeprom_op_go), .flash_suspend_req(flash_suspend_req),
    .wait_instruction(wait_instruction), .halt_stop(halt_stop), .wake(wake),
    .flash_standby(flash_standby), .mem_power_down(mem_power_down), .ext_irq(ext_irq),
    .shared_interrupt_channel(shared_interrupt_channel));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ************************************************
  // shared tasks
  // ************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rw(input logic [23:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk("reg_rdata", reg_rdata, e);
  endtask
  // a refused store shows only as a missing strobe
  task automatic store(input logic fl, input logic ok, input logic [4:0] cnt);
    @(negedge clk);
    flash_wr = fl;
    eeprom_wr = ~fl;
    @(negedge clk);
    flash_wr = 1'b0;
    eeprom_wr = 1'b0;
    chk("latch_strobe", {7'h00, latch_strobe}, {7'h00, ok});
    if (ok) chk("latch_count", {3'h0, latch_count}, {3'h0, cnt});
  endtask
  task automatic arr(input logic fl, input logic [7:0] e);
    @(negedge clk);
    flash_sel = fl;
    array_rd = 1'b1;
    @(negedge clk);
    array_rd = 1'b0;
    @(negedge clk);
    chk("array_data_out", array_data_out, e);
  endtask
  // completion pulse, then end-of-write irq expected with select set
  task automatic finish_op(input logic fl);
    @(negedge clk);
    flash_op_done = fl;
    eeprom_op_done = ~fl;
    @(negedge clk);
    flash_op_done = 1'b0;
    eeprom_op_done = 1'b0;
    chk("shared_interrupt_channel", {7'h00, shared_interrupt_channel}, 8'h01);
  endtask
  task automatic pulse_in(input int k);
    @(negedge clk);
    wait_instruction = (k == 0);
    halt_stop = (k == 1);
    wake = (k == 2);
    @(negedge clk);
    {wait_instruction, halt_stop, wake} = 3'h0;
  endtask
  // hang guard: far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ************************************************
  // tests
  // ************************************************
  initial begin
    {rst_n, reg_wr, reg_rd, flash_wr, eeprom_wr, array_rd, flash_sel} = 7'h00;
    {flash_op_done, eeprom_op_done, wait_instruction, halt_stop, wake, ext_irq} = 6'h00;
    reg_addr = 24'h000000;
    reg_wdata = 8'h00;
    array_rdata = 8'h5a;
    n_errors = 0;
    check_count = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd(`FEWC_FCR_ADDR, 8'h01); // flash waking
    rd(`FEWC_ECR_ALT_ADDR, 8'h01); // eeprom waking
    repeat (FW) @(negedge clk);
    rd(`FEWC_FCR_ALT_ADDR, 8'h00); // flash ready first
    rd(`FEWC_ECR_ADDR, 8'h01); // eeprom still waking
    repeat (EW) @(negedge clk);
    rd(`FEWC_ECR_ADDR, 8'h00); // eeprom ready
    rd(24'h224005, 8'h00);
    ext_irq = 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk("shared_interrupt_channel", {7'h00, shared_interrupt_channel}, 8'h01); // pin routed
    rw(`FEWC_ECR_ADDR, 8'h02);
    @(negedge clk);
    chk("shared_interrupt_channel", {7'h00, shared_interrupt_channel}, 8'h00); // pin blocked
    ext_irq = 1'b0;
    $display("test reset and irq routing done");
    rw(`FEWC_FCR_ADDR, 8'h10);
    store(1'b1, 1'b1, 5'd1); // one pair taken
    store(1'b1, 1'b0, 5'd1); // second pair refused
    rd(`FEWC_FCR_ADDR, 8'h11); // busy on first latch
    arr(1'b1, `FEWC_ERASED); // busy flash reads ff
    rw(`FEWC_FCR_ADDR, 8'h90);
    chk("flash_op_go", {7'h00, flash_op_go}, 8'h01); // start launches
    rw(`FEWC_FCR_ADDR, 8'h10);
    rd(`FEWC_FCR_ADDR, 8'h91); // clear of start ignored
    finish_op(1'b1); // end-of-write irq
    rd(`FEWC_FCR_ADDR, 8'h00); // select and start self-clear
    arr(1'b1, 8'h5a); // reads pass when idle
    $display("test byte program done");
    rw(`FEWC_FCR_ADDR, 8'h40);
    store(1'b1, 1'b1, 5'd1);
    rw(`FEWC_FCR_ADDR, 8'h00);
    rw(`FEWC_FCR_ADDR, 8'h40);
    store(1'b1, 1'b1, 5'd1); // cancel dropped latches
    for (int i = 2; i <= 17; i++) store(1'b1, i <= 16, 5'(i)); // up to sixteen pairs
    rw(`FEWC_FCR_ADDR, 8'hc0);
    chk("flash_op_go", {7'h00, flash_op_go}, 8'h01); // page start
    finish_op(1'b1);
    rd(`FEWC_FCR_ADDR, 8'h00); // page select self-clears
    rw(`FEWC_FCR_ADDR, 8'h02);
    for (int i = 1; i <= 5; i++) store(1'b1, i <= 4, 5'(i)); // up to four bytes
    rw(`FEWC_FCR_ADDR, 8'h82);
    finish_op(1'b1);
    rd(`FEWC_FCR_ADDR, 8'h00); // protection select self-clears
    rw(`FEWC_FCR_ADDR, 8'h20);
    rw(`FEWC_FCR_ADDR, 8'ha0);
    rd(`FEWC_FCR_ADDR, 8'ha1); // chip erase busy on start
    finish_op(1'b1);
    rd(`FEWC_FCR_ADDR, 8'h00); // chip erase ends clean
    $display("test page protection chip done");
    rw(`FEWC_FCR_ADDR, 8'h08);
    for (int i = 1; i <= 7; i++) store(1'b1, i <= 6, 5'(i)); // up to six sectors
    rw(`FEWC_FCR_ADDR, 8'h88);
    rw(`FEWC_FCR_ADDR, 8'h0c);
    @(negedge clk);
    chk("flash_suspend_req", {7'h00, flash_suspend_req}, 8'h01); // suspend pending
    repeat (SC) @(negedge clk);
    rd(`FEWC_FCR_ADDR, 8'h0c); // start and busy cleared
    rw(`FEWC_ECR_ADDR, 8'h42);
    store(1'b0, 1'b0, 5'd0); // eeprom update refused
    rw(`FEWC_ECR_ADDR, 8'h02);
    rw(`FEWC_FCR_ADDR, 8'h88);
    @(negedge clk);
    chk("flash_op_go", {7'h00, flash_op_go}, 8'h01); // resume relaunches
    rd(`FEWC_FCR_ADDR, 8'h89); // busy again
    finish_op(1'b1);
    rd(`FEWC_FCR_ADDR, 8'h00); // sector select self-clears
    $display("test sector suspend done");
    rw(`FEWC_ECR_ADDR, 8'h42);
    for (int i = 1; i <= 17; i++) store(1'b0, i <= 16, 5'(i)); // up to sixteen bytes
    rd(`FEWC_ECR_ADDR, 8'h43); // eeprom busy on first latch
    arr(1'b0, `FEWC_ERASED); // busy eeprom reads ff
    rw(`FEWC_ECR_ADDR, 8'hc2);
    chk("eeprom_op_go", {7'h00, eeprom_op_go}, 8'h01); // start launches
    rw(`FEWC_ECR_ADDR, 8'h42);
    rd(`FEWC_ECR_ADDR, 8'hc3); // clear of start ignored
    finish_op(1'b0);
    rd(`FEWC_ECR_ADDR, 8'h02); // page select self-clears
    rw(`FEWC_ECR_ADDR, 8'h22);
    rw(`FEWC_ECR_ADDR, 8'ha2);
    rd(`FEWC_ECR_ADDR, 8'ha3); // busy on start
    finish_op(1'b0);
    rd(`FEWC_ECR_ADDR, 8'h02); // chip select self-clears
    $display("test eeprom done");
    rw(`FEWC_ECR_ADDR, 8'h06);
    pulse_in(0);
    repeat (2) @(negedge clk);
    chk("mem_power_down", {7'h00, mem_power_down}, 8'h01); // deep wait
    pulse_in(2);
    rd(`FEWC_FCR_ADDR, 8'h01); // busy after power-down exit
    repeat (EW + 5) @(negedge clk);
    rw(`FEWC_ECR_ADDR, 8'h02);
    pulse_in(0);
    repeat (2) @(negedge clk);
    chk("flash_standby", {7'h00, flash_standby}, 8'h01); // light wait
    pulse_in(2);
    repeat (4) @(negedge clk);
    rw(`FEWC_FCR_ADDR, 8'h10);
    store(1'b1, 1'b1, 5'd1);
    rw(`FEWC_FCR_ADDR, 8'h90);
    pulse_in(1);
    repeat (3) @(negedge clk);
    chk("mem_power_down", {7'h00, mem_power_down}, 8'h00); // deferred while writing
    finish_op(1'b1);
    repeat (3) @(negedge clk);
    chk("mem_power_down", {7'h00, mem_power_down}, 8'h01); // entered after write
    $display("test power modes done");
    wrap_up();
  end
endmodule // fewc_ctrl_tb_top
